// ===== core/sle_status_lamp_encoder.sv
// Purpose: Front-panel lamp encoder for a networked motor driver, APB slave
// Assumes: Software mirrors driver and network state into the status words
// Notes:   One wait state; refused accesses answer with pslverr; lamp outputs are registered
`include "sle_defs.svh"

module sle_status_lamp_encoder #(
    parameter int unsigned MS_TICK_CYC   = `SLE_MS_NS / `SLE_CLK_PERIOD_NS,
    parameter int unsigned BLINK_HALF_MS = `SLE_BLINK_HALF_MS,
    parameter int unsigned GAP_MS        = `SLE_GAP_MS,
    parameter int unsigned ACT_HOLD_MS   = `SLE_ACT_HOLD_MS
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`SLE_ADDR_W-1:0]    paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output sle_pkg::sle_lamp_t             power_alarm_lamp,
    output sle_pkg::sle_lamp_t             module_status_lamp,
    output sle_pkg::sle_lamp_t             network_status_lamp,
    output logic                           link_activity_lamp
);
    import sle_pkg::*;

    function automatic sle_lamp_t mk_lamp(input logic g, input logic r);
        sle_lamp_t l;
        l.green = g;
        l.red   = r;
        return l;
    endfunction

    function automatic logic ms_reached(input logic [15:0] cnt, input int unsigned lim);
        return cnt >= 16'(lim - 1);
    endfunction

    // ---------------- APB slave ----------------
    logic [31:0]    drv_r;
    logic [31:0]    net_r;
    logic [31:0]    irt_r;
    logic [31:0]    prdata_r;
    logic           pready_r;
    logic           pslverr_r;

    wire hit_drv  = paddr == `SLE_OFS_DRV;
    wire hit_net  = paddr == `SLE_OFS_NET;
    wire hit_evt  = paddr == `SLE_OFS_EVT;
    wire hit_irt  = paddr == `SLE_OFS_IRT;
    wire hit_lamp = paddr == `SLE_OFS_LAMP;
    wire hit_any  = hit_drv | hit_net | hit_evt | hit_irt | hit_lamp;
    // Lamp word is read-only; a write to it is refused with an error
    wire bad_acc  = ~hit_any | (pwrite & hit_lamp);
    // First access cycle prepares the answer, second one completes it
    wire acc_wait = psel & penable & ~pready_r;
    wire commit   = psel & penable & pready_r;
    wire wr_ok    = commit & pwrite & ~pslverr_r;
    wire wr_drv   = wr_ok & hit_drv;
    wire wr_net   = wr_ok & hit_net;
    wire wr_evt   = wr_ok & hit_evt;
    wire wr_irt   = wr_ok & hit_irt;

    wire ev_stop_clr = wr_evt & pwdata[`SLE_EVT_STOP_CLR];
    wire ev_ilk_rel  = wr_evt & pwdata[`SLE_EVT_ILK_REL];
    wire ev_frame    = wr_evt & pwdata[`SLE_EVT_FRAME];

    logic [31:0] lamp_word;
    wire  [31:0] rd_mux = hit_drv  ? drv_r :
                          hit_net  ? net_r :
                          hit_irt  ? irt_r :
                          hit_lamp ? lamp_word : `SLE_RST_WORD;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= `SLE_RST_WORD;
        end else begin
            pready_r  <= acc_wait;
            pslverr_r <= acc_wait & bad_acc;
            if (acc_wait) begin
                prdata_r <= (pwrite | bad_acc) ? `SLE_RST_WORD : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_r <= `SLE_RST_WORD;
            net_r <= `SLE_RST_WORD;
            irt_r <= `SLE_RST_WORD;
        end else begin
            if (wr_drv) drv_r <= pwdata & `SLE_DRV_MASK;
            if (wr_net) net_r <= pwdata & `SLE_NET_MASK;
            if (wr_irt) irt_r <= pwdata & `SLE_IRT_MASK;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ---------------- Status fields ----------------
    wire       alarm      = drv_r[`SLE_DRV_ALARM];
    wire       alm_rst    = drv_r[`SLE_DRV_ALM_RST];
    wire       info       = drv_r[`SLE_DRV_INFO];
    wire       teach      = drv_r[`SLE_DRV_TEACH];
    wire [7:0] alm_code   = drv_r[`SLE_DRV_CODE_HI:`SLE_DRV_CODE_LO];
    wire       origin     = drv_r[`SLE_DRV_ORIGIN];
    wire       sim        = drv_r[`SLE_DRV_SIM];
    wire       diag       = drv_r[`SLE_DRV_DIAG];
    wire       removal    = drv_r[`SLE_DRV_REMOVAL];
    wire       cfg_bad    = net_r[`SLE_NET_CFG_BAD];
    wire       online     = net_r[`SLE_NET_ONLINE];
    wire       conn       = net_r[`SLE_NET_CONN];
    wire       conn_tmo   = net_r[`SLE_NET_TIMEOUT];
    wire       dup_ip     = net_r[`SLE_NET_DUP_IP];
    wire       link_up    = net_r[`SLE_NET_LINK];

    // ---------------- Time base ----------------
    // tick period
    logic [17:0] ms_cnt_r;
    wire         ms_tick = ms_cnt_r == 18'(MS_TICK_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ms_cnt_r <= '0;
        else          ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 18'h1;
    end

    // Free-running blink phase shared by all plain blinking lamps
    logic [15:0] blk_cnt_r;
    logic        blk_ph_r;
    logic [1:0]  sim_ph_r;
    wire         blk_step = ms_tick & ms_reached(blk_cnt_r, BLINK_HALF_MS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_cnt_r <= '0;
            blk_ph_r  <= 1'b0;
            sim_ph_r  <= 2'h0;
        end else if (ms_tick) begin
            blk_cnt_r <= blk_step ? '0 : blk_cnt_r + 16'h1;
            if (blk_step) begin
                blk_ph_r <= ~blk_ph_r;
                sim_ph_r <= sim_ph_r + 2'h1;
            end
        end
    end

    // ---------------- Latched conditions ----------------
    logic        removal_r;
    logic [15:0] ilk_cnt_r;
    logic [15:0] act_cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            removal_r <= 1'b0;
        end else if (removal) begin
            removal_r <= 1'b1;
        end else if (ev_stop_clr) begin
            removal_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ilk_cnt_r <= '0;
        end else if (ev_ilk_rel) begin
            ilk_cnt_r <= irt_r[15:0];
        end else if (ms_tick && ilk_cnt_r != '0) begin
            ilk_cnt_r <= ilk_cnt_r - 16'h1;
        end
    end

    // traffic hold, a new frame restarts it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_cnt_r <= '0;
        end else if (ev_frame) begin
            act_cnt_r <= 16'(ACT_HOLD_MS);
        end else if (ms_tick && act_cnt_r != '0) begin
            act_cnt_r <= act_cnt_r - 16'h1;
        end
    end

    // ---------------- Power/alarm mode ----------------
    sle_pa_mode_t pa_mode;
    sle_pa_mode_t pa_mode_r;

    // priority order; simulation outranks all as a whole-driver mode
    assign pa_mode = sim                ? SLE_PA_SIM     :
                     alarm              ? SLE_PA_ALARM   :
                     removal_r          ? SLE_PA_REMOVAL :
                     origin             ? SLE_PA_ORIGIN  :
                     (ilk_cnt_r != '0)  ? SLE_PA_ILK     :
                     (info | teach)     ? SLE_PA_INFO    : SLE_PA_GREEN;

    // Counted pattern: alarm code for alarms (one when the code is zero), two for information
    wire [7:0] pat_len  = (pa_mode == SLE_PA_ALARM) ? ((alm_code == 8'h0) ? 8'h1 : alm_code)
                                                    : 8'h2;
    wire       pat_rest = pa_mode != pa_mode_r;

    sle_pat_state_t ps_r;
    logic [15:0]    ps_cnt_r;
    logic [7:0]     ps_blinks_r;
    wire            ps_half = ms_tick & ms_reached(ps_cnt_r, BLINK_HALF_MS);
    wire            ps_gap  = ms_tick & ms_reached(ps_cnt_r, GAP_MS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_mode_r   <= SLE_PA_GREEN;
            ps_r        <= SLE_PS_ON;
            ps_cnt_r    <= '0;
            ps_blinks_r <= '0;
        end else begin
            pa_mode_r <= pa_mode;
            if (pat_rest) begin
                ps_r        <= SLE_PS_ON;
                ps_cnt_r    <= '0;
                ps_blinks_r <= '0;
            end else if (ms_tick) begin
                ps_cnt_r <= ps_cnt_r + 16'h1;
                unique case (ps_r)
                    SLE_PS_ON: begin
                        if (ps_half) begin
                            ps_r        <= SLE_PS_OFF;
                            ps_cnt_r    <= '0;
                            ps_blinks_r <= ps_blinks_r + 8'h1;
                        end
                    end
                    SLE_PS_OFF: begin
                        if (ps_half) begin
                            ps_r     <= (ps_blinks_r >= pat_len) ? SLE_PS_GAP : SLE_PS_ON;
                            ps_cnt_r <= '0;
                        end
                    end
                    SLE_PS_GAP: begin
                        if (ps_gap) begin
                            ps_r        <= SLE_PS_ON;
                            ps_cnt_r    <= '0;
                            ps_blinks_r <= '0;
                        end
                    end
                    default: begin
                        ps_r     <= SLE_PS_ON;
                        ps_cnt_r <= '0;
                    end
                endcase
            end
        end
    end

    wire pat_on = ps_r == SLE_PS_ON;

    sle_lamp_t pa_nxt;
    always_comb begin
        unique case (pa_mode)
            SLE_PA_SIM:     pa_nxt = mk_lamp(~sim_ph_r[1] & ~sim_ph_r[0] | (sim_ph_r == 2'h2),
                                             sim_ph_r == 2'h1 | sim_ph_r == 2'h2);
            SLE_PA_ALARM:   pa_nxt = mk_lamp(1'b0, pat_on);
            SLE_PA_REMOVAL: pa_nxt = mk_lamp(blk_ph_r, 1'b0);
            SLE_PA_ORIGIN:  pa_nxt = mk_lamp(1'b1, 1'b1);
            SLE_PA_ILK:     pa_nxt = mk_lamp(blk_ph_r, blk_ph_r);
            SLE_PA_INFO:    pa_nxt = mk_lamp(pat_on, pat_on);
            default:        pa_nxt = mk_lamp(1'b1, 1'b0);
        endcase
    end

    // ---------------- Module status ----------------
    sle_lamp_t ms_nxt;
    sle_lamp_t alt_lamp;
    assign alt_lamp = mk_lamp(blk_ph_r, ~blk_ph_r);

    always_comb begin
        if (diag) begin
            ms_nxt = alt_lamp;
        end else if (alarm && !alm_rst) begin
            ms_nxt = mk_lamp(1'b0, 1'b1);
        end else if ((alarm && alm_rst) || dup_ip) begin
            ms_nxt = mk_lamp(1'b0, blk_ph_r);
        end else if (cfg_bad) begin
            ms_nxt = mk_lamp(blk_ph_r, 1'b0);
        end else begin
            ms_nxt = mk_lamp(1'b1, 1'b0);
        end
    end

    // ---------------- Network status ----------------
    sle_lamp_t ns_nxt;
    always_comb begin
        if (diag) begin
            ns_nxt = alt_lamp;
        end else if (dup_ip) begin
            ns_nxt = mk_lamp(1'b0, 1'b1);
        end else if (conn_tmo) begin
            ns_nxt = mk_lamp(1'b0, blk_ph_r);
        end else if (!online) begin
            ns_nxt = mk_lamp(1'b0, 1'b0);
        end else if (conn) begin
            ns_nxt = mk_lamp(1'b1, 1'b0);
        end else begin
            ns_nxt = mk_lamp(blk_ph_r, 1'b0);
        end
    end

    wire la_nxt = link_up & ((act_cnt_r != '0) ? blk_ph_r : 1'b1);

    // ---------------- Output flops ----------------
    sle_lamp_t pa_r;
    sle_lamp_t ms_r;
    sle_lamp_t ns_r;
    logic      la_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_r <= '0;
            ms_r <= '0;
            ns_r <= '0;
            la_r <= 1'b0;
        end else begin
            pa_r <= pa_nxt;
            ms_r <= ms_nxt;
            ns_r <= ns_nxt;
            la_r <= la_nxt;
        end
    end

    assign power_alarm_lamp    = pa_r;
    assign module_status_lamp  = ms_r;
    assign network_status_lamp = ns_r;
    assign link_activity_lamp  = la_r;

    // Read-back of what the panel shows plus internal progress
    assign lamp_word = {8'h0, ps_blinks_r, 1'b0, pa_mode_r, removal_r,
                        (ilk_cnt_r != '0), (act_cnt_r != '0), la_r,
                        ns_r, ms_r, pa_r, 2'h0};

endmodule

// ===== common/sle_defs.svh
// Purpose: Named offsets, field positions and timing figures of the lamp encoder
// Assumes: 200 MHz pclk; register offsets are byte addresses on APB
// Notes:   Times are in their own units; cycle counts are derived in the core
`ifndef SLE_DEFS_SVH
`define SLE_DEFS_SVH

`define SLE_ADDR_W          12
`define SLE_OFS_DRV         12'h000
`define SLE_OFS_NET         12'h004
`define SLE_OFS_EVT         12'h008
`define SLE_OFS_IRT         12'h00C
`define SLE_OFS_LAMP        12'h010

// Driver status word
`define SLE_DRV_ALARM       0
`define SLE_DRV_ALM_RST     1
`define SLE_DRV_INFO        2
`define SLE_DRV_TEACH       3
`define SLE_DRV_CODE_LO     4
`define SLE_DRV_CODE_HI     11
`define SLE_DRV_ORIGIN      12
`define SLE_DRV_SIM         13
`define SLE_DRV_DIAG        14
`define SLE_DRV_REMOVAL     15
`define SLE_DRV_MASK        32'h0000_FFFF

// Network status word
`define SLE_NET_CFG_BAD     0
`define SLE_NET_ONLINE      1
`define SLE_NET_CONN        2
`define SLE_NET_TIMEOUT     3
`define SLE_NET_DUP_IP      4
`define SLE_NET_LINK        5
`define SLE_NET_MASK        32'h0000_003F

// Event word, write one to fire
`define SLE_EVT_STOP_CLR    0
`define SLE_EVT_ILK_REL     1
`define SLE_EVT_FRAME       2

`define SLE_IRT_MASK        32'h0000_FFFF
`define SLE_RST_WORD        32'h0000_0000

// Timing, in nanoseconds and milliseconds
`define SLE_CLK_PERIOD_NS   5
`define SLE_MS_NS           1000000
`define SLE_BLINK_HALF_MS   250
`define SLE_GAP_MS          1000
`define SLE_ACT_HOLD_MS     50

`endif

// ===== common/sle_pkg.sv
// Purpose: Types shared by the lamp encoder and its bench
// Assumes: sle_defs.svh holds the numbers
// Notes:   A two-colour lamp travels as one packed pair
package sle_pkg;

    typedef struct packed {
        logic green;
        logic red;
    } sle_lamp_t;

    // Alarm-count pattern sequencer, Gray along on -> off -> gap
    typedef enum logic [1:0] {
        SLE_PS_ON  = 2'b00,
        SLE_PS_OFF = 2'b01,
        SLE_PS_GAP = 2'b11
    } sle_pat_state_t;

    typedef enum logic [2:0] {
        SLE_PA_GREEN    = 3'h0,
        SLE_PA_SIM      = 3'h1,
        SLE_PA_ALARM    = 3'h3,
        SLE_PA_REMOVAL  = 3'h2,
        SLE_PA_ORIGIN   = 3'h6,
        SLE_PA_ILK      = 3'h7,
        SLE_PA_INFO     = 3'h5
    } sle_pa_mode_t;

endpackage

// ===== dv/sle_lamp_viewer.sv
// Purpose: Operator model that notes which colour mixes a lamp showed
// Assumes: Lamp outputs are registered levels, high means lit
// Notes:   Index of seen is {green,red}; a steady lamp sets one bit only
module sle_lamp_viewer (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               clear,
    input  wire sle_pkg::sle_lamp_t lamp,
    output logic [3:0]              seen
);
    timeunit 1ns;
    timeprecision 1ps;
    import sle_pkg::*;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen <= 4'h0;
        end else if (clear) begin
            seen <= 4'h0;
        end else begin
            seen <= seen | (4'h1 << {lamp.green, lamp.red});
        end
    end
endmodule

// ===== dv/sle_status_lamp_encoder_assertions.sv
// Purpose: Port-level checks of the lamp encoder and its APB slave
// Assumes: Master holds each request until pready, as APB asks
// Notes:   Status words are shadowed from committed writes
`include "sle_defs.svh"

module sle_status_lamp_encoder_assertions (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`SLE_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire sle_pkg::sle_lamp_t     power_alarm_lamp,
    input wire sle_pkg::sle_lamp_t     module_status_lamp,
    input wire sle_pkg::sle_lamp_t     network_status_lamp,
    input wire logic                   link_activity_lamp
);
    timeunit 1ns;
    timeprecision 1ps;
    import sle_pkg::*;

    logic [31:0] drv_r;
    logic [31:0] net_r;
    wire         wr_done = psel && penable && pwrite && pready;

    // Lamps lag the register by one edge, so conditions must hold two samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_r <= 32'h0;
            net_r <= 32'h0;
        end else if (wr_done) begin
            if (paddr == `SLE_OFS_DRV) drv_r <= pwdata;
            if (paddr == `SLE_OFS_NET) net_r <= pwdata;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_access;
        psel && penable;
    endsequence

    one_wait_a: assert property (apb_setup ##1 apb_access |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr without completion");
    lamp_wr_err_a: assert property (psel && penable && pready && pwrite &&
        paddr == `SLE_OFS_LAMP |-> pslverr) else $error("lamp write not refused");
    unmapped_err_a: assert property (pready && paddr > `SLE_OFS_LAMP |-> pslverr)
        else $error("unmapped access not refused");
    alarm_red_a: assert property ((drv_r[0] && !drv_r[13]) [*2] |->
        !power_alarm_lamp.green) else $error("green lit during alarm");
    fatal_red_a: assert property ((drv_r[0] && !drv_r[1] && !drv_r[14]) [*2] |->
        module_status_lamp == 2'h1) else $error("module lamp not steady red");
    ms_green_a: assert property ((!drv_r[0] && !drv_r[14] && !net_r[4] && !net_r[0]) [*2]
        |-> module_status_lamp == 2'h2) else $error("module lamp not steady green");
    dup_red_a: assert property ((net_r[4] && !drv_r[14]) [*2] |->
        network_status_lamp == 2'h1) else $error("network lamp not steady red");
    offline_dark_a: assert property ((!drv_r[14] && !net_r[4] && !net_r[3] && !net_r[1]) [*2]
        |-> network_status_lamp == 2'h0) else $error("network lamp lit offline");
    link_off_a: assert property ((!net_r[5]) [*2] |-> !link_activity_lamp)
        else $error("link lamp lit with link down");
    diag_alt_a: assert property (drv_r[14] [*2] |->
        module_status_lamp.green != module_status_lamp.red &&
        network_status_lamp.green != network_status_lamp.red)
        else $error("self-diagnosis colours not alternate");
endmodule

bind sle_status_lamp_encoder sle_status_lamp_encoder_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_alarm_lamp(power_alarm_lamp), .module_status_lamp(module_status_lamp),
    .network_status_lamp(network_status_lamp), .link_activity_lamp(link_activity_lamp)
);

// ===== dv/test_status_lamp_encoder.sv
// Purpose: Self-checking bench of the lamp encoder over APB
// Assumes: Short timing parameters: 4 cycles a ms tick, 8 cycles a blink half
// Notes:   Each scenario packs what the four viewers saw into one word
`include "sle_defs.svh"

module test_status_lamp_encoder;
    timeunit 1ns;
    timeprecision 1ps;
    import sle_pkg::*;

    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [`SLE_ADDR_W-1:0] paddr = 12'h000;
    logic [31:0]            pwdata = 32'h0;
    logic [31:0]            prdata, rd, seed;
    logic                   pready, pslverr, er, link;
    logic                   view_clr = 1'b0;
    sle_lamp_t              pa, ms, ns;
    sle_lamp_t              lamps [4];
    logic [3:0]             seen [4];
    int                     error_cnt = 0;
    int                     checks = 0;
    int                     cyc = 0;
    int                     red_rises = 0;
    logic                   red_q = 1'b0;

    always #2.5 pclk = ~pclk;

    sle_status_lamp_encoder #(.MS_TICK_CYC(4), .BLINK_HALF_MS(2), .GAP_MS(4),
        .ACT_HOLD_MS(3)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_alarm_lamp(pa), .module_status_lamp(ms),
        .network_status_lamp(ns), .link_activity_lamp(link));

    assign lamps[0] = pa;
    assign lamps[1] = ms;
    assign lamps[2] = ns;
    assign lamps[3] = sle_lamp_t'({link, 1'b0});
    for (genvar i = 0; i < 4; i++) begin : g_view
        sle_lamp_viewer u_view (.pclk(pclk), .presetn(presetn), .clear(view_clr),
            .lamp(lamps[i]), .seen(seen[i]));
    end

    // Red rises of the power/alarm lamp within one viewing window
    always @(posedge pclk) begin
        red_q <= pa.red;
        if (view_clr)
            red_rises <= 0;
        else if (pa.red && !red_q)
            red_rises <= red_rises + 1;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait as long as the slave needs; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Clear the viewers, then let them look for n cycles
    task automatic watch(input int n);
        view_clr <= 1'b1;
        @(posedge pclk);
        view_clr <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask

    task automatic scen(input logic [31:0] drv, input logic [31:0] net, input logic [15:0] e);
        apb(1'b1, `SLE_OFS_DRV, drv);
        apb(1'b1, `SLE_OFS_NET, net);
        repeat (4) @(posedge pclk);
        watch(64);
        chk("lamps", {16'h0, seen[0], seen[1], seen[2], seen[3]}, {16'h0, e});
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        seed = 32'h1E70;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SLE_OFS_LAMP, 32'h0);
        chk("lamp word", rd, 32'h28);
        foreach (lamps[i]) begin
            apb(1'b0, 12'(4 * (i % 4)), 32'h0);
            chk("reset word", rd, `SLE_RST_WORD);
        end
        // Random words; upper bits must read back as zero
        repeat (4) begin
            seed = lfsr(seed);
            apb(1'b1, `SLE_OFS_DRV, seed);
            apb(1'b0, `SLE_OFS_DRV, 32'h0);
            chk("drv word", rd, seed & `SLE_DRV_MASK);
            apb(1'b1, `SLE_OFS_NET, ~seed);
            apb(1'b0, `SLE_OFS_NET, 32'h0);
            chk("net word", rd, ~seed & `SLE_NET_MASK);
            apb(1'b1, `SLE_OFS_IRT, seed);
            apb(1'b0, `SLE_OFS_IRT, 32'h0);
            chk("irt word", rd, seed & `SLE_IRT_MASK);
        end
        apb(1'b1, `SLE_OFS_LAMP, 32'hFFFFFFFF);
        chk("lamp write err", {31'h0, er}, 32'h1);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b0, `SLE_OFS_EVT, 32'h0);
        chk("evt read", {31'h0, er} | rd, 32'h0);
        apb(1'b1, `SLE_OFS_DRV, 32'h0);
        apb(1'b1, `SLE_OFS_EVT, 32'h1);
        scen(32'h0, 32'h0, 16'h4411);
        scen(32'h33, 32'h02, 16'h3351);
        chk("alarm blinks", red_rises, 32'h3);
        scen(32'h11, 32'h06, 16'h3241);
        scen(32'h04, 32'h0B, 16'h9531);
        scen(32'h08, 32'h12, 16'h9321);
        scen(32'h1000, 32'h22, 16'h8454);
        scen(32'h2000, 32'h00, 16'hF411);
        scen(32'h4000, 32'h02, 16'h4661);
        scen(32'h8011, 32'h02, 16'h3251);
        chk("alarm blinks", red_rises, 32'h2);
        scen(32'h8000, 32'h02, 16'h5451);
        scen(32'h0, 32'h02, 16'h5451);
        apb(1'b1, `SLE_OFS_EVT, 32'h1);
        scen(32'h0, 32'h02, 16'h4451);
        apb(1'b1, `SLE_OFS_IRT, 32'hA);
        apb(1'b1, `SLE_OFS_EVT, 32'h2);
        watch(24);
        chk("interlock blink", {28'h0, seen[0]}, 32'h9);
        repeat (40) @(posedge pclk);
        watch(24);
        chk("interlock end", {28'h0, seen[0]}, 32'h4);
        apb(1'b1, `SLE_OFS_NET, 32'h22);
        repeat (3) apb(1'b1, `SLE_OFS_EVT, 32'h4);
        watch(0);
        repeat (12) apb(1'b1, `SLE_OFS_EVT, 32'h4);
        chk("traffic blink", {28'h0, seen[3]}, 32'h5);
        close_out();
    end
endmodule
